// ===== hw/ssp_defines.svh
// Purpose: constants of the shared serial port
// Assumes: 8-bit special function register port
// Notes: addresses are register addresses on that port
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ****************************************
// Register addresses
// ****************************************
`define SSP_ADDR_I2C_DATA 8'h9A
`define SSP_ADDR_I2C_ADDRESS 8'h9B
`define SSP_ADDR_I2C_CONTROL 8'hE8
`define SSP_ADDR_SPI_CONTROL 8'hF8
`define SSP_ADDR_SPI_DATA 8'hF7

// ****************************************
// Reset values
// ****************************************
`define SSP_RST_I2C_DATA 8'h00
`define SSP_RST_I2C_ADDRESS 8'h55
`define SSP_RST_I2C_CONTROL 8'h00
`define SSP_RST_SPI_CONTROL 8'h04

// ****************************************
// Control field positions
// ****************************************
`define SSP_SPI_DONE_BIT 7
`define SSP_SPI_WRITE_COLLISION_FLAG_BIT 6
`define SSP_SPI_EN_BIT 5
`define SSP_SPI_MASTER_BIT 4
`define SSP_SPI_CPOL_BIT 3
`define SSP_SPI_CPHA_BIT 2
`define SSP_I2C_MDO_BIT 7
`define SSP_I2C_MDE_BIT 6
`define SSP_I2C_MCO_BIT 5
`define SSP_I2C_MDI_BIT 4
`define SSP_I2C_ROLE_BIT 3
`define SSP_I2C_SRST_BIT 2
`define SSP_I2C_DIR_BIT 1
`define SSP_I2C_FLAG_BIT 0

// ****************************************
// Timing
// ****************************************
`define SSP_SPI_HALF_BASE 1
`define SSP_SPI_LAST_EDGE 5'h0F

`endif

// ===== hw/ssp_pkg.sv
// Purpose: types of the shared serial port
// Assumes: nothing beyond the defines header
// Notes: pin drive pairs travel as one struct
package ssp_pkg;

	typedef struct packed {
		logic out;
		logic oe;
	} ssp_pin_s;

	typedef enum logic [2:0] {
		SSP_I2C_IDLE = 3'b000,
		SSP_I2C_ADDR = 3'b001,
		SSP_I2C_AACK = 3'b010,
		SSP_I2C_RX = 3'b011,
		SSP_I2C_RACK = 3'b100,
		SSP_I2C_TX = 3'b101,
		SSP_I2C_TACK = 3'b110
	} ssp_i2c_e;

endpackage

// ===== hw/ssp_sync2.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to mclk_in
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module ssp_sync2 #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_ff <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // ssp_sync2

// ===== hw/ssp_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock domain
// Notes: head word comes from a register
`timescale 1ns/1ps
module ssp_buf2 #(
	parameter int WIDTH = 8
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem_ff [2];
	logic rd_ptr_ff;
	logic wr_ptr_ff;
	logic [1:0] cnt_ff;
	wire push = in_valid_in && (cnt_ff != 2'h2);
	wire pop = out_ready_in && (cnt_ff != 2'h0);

	if (WIDTH < 1) begin : g_chk
		$error("ssp_buf2: WIDTH must be at least 1");
	end

	assign in_ready_out = (cnt_ff != 2'h2);
	assign out_valid_out = (cnt_ff != 2'h0);
	assign out_data_out = mem_ff[rd_ptr_ff];

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
			rd_ptr_ff <= 1'b0;
			wr_ptr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) begin
				mem_ff[wr_ptr_ff] <= in_data_in;
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // ssp_buf2

// ===== hw/ssp_top.sv
// Purpose: shared SPI and I2C-compatible serial port
// Assumes: register port on mclk_in, pins asynchronous
// Notes: pin drives are registered; I2C pins are open drain
`timescale 1ns/1ps
`include "ssp_defines.svh"

// Notes on behaviour
// - Full-duplex byte transfers, MSB first
// - MISO input as master, driven as slave
// - MOSI driven as master, input as slave
// - One bit per clock period, eight periods
// - Clock driven as master, input as slave
// - Rate, polarity, phase from control bits
// - Launch one edge, sample the other
// - Slave acts only while select low
// - Done flag set per byte, cleared
// - Write during transfer sets collision flag
// - Protocol select chooses SPI or I2C
// - Role bit chooses SPI master or slave
// - Polarity bit sets clock idle level
// - I2C uses shared data and clock
// - Software master bits drive pins
// - Drive bit enables data pin output
// - Data pin latched on clock when undriven
// - I2C role bit: software master or slave
// - Soft reset bit holds I2C slave idle
// - Direction bit shows slave transmitting
// - Byte flag set, cleared by data access
module ssp_top import ssp_pkg::*; #(
	parameter int HALF_BASE = `SSP_SPI_HALF_BASE
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic serial_clock_pin_in,
	output ssp_pin_s serial_clock_pin_drv_out,
	input wire logic serial_data_pin_in,
	output ssp_pin_s serial_data_pin_drv_out,
	input wire logic miso_pin_in,
	output ssp_pin_s miso_pin_drv_out,
	input wire logic slave_select_n_in
);
	if (HALF_BASE < 1 || HALF_BASE > 31) begin : g_chk
		$error("ssp_top: HALF_BASE out of range");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] half_cycles(input logic [1:0] sel);
		half_cycles = 8'(HALF_BASE << sel);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// ****************************************
	// Registers and pin synchronisers
	// ****************************************
	logic [7:0] spi_ctl_ff;
	logic [7:0] i2c_ctl_ff;
	logic [7:0] i2c_adr_ff;
	logic [7:0] i2c_dat_ff;
	logic [3:0] pin_sync;
	logic [3:0] pin_prev_ff;

	ssp_sync2 #(.WIDTH(4), .RESET_VAL(4'hF)) u_sync (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.async_in({serial_clock_pin_in, serial_data_pin_in, miso_pin_in,
			slave_select_n_in}),
		.sync_out(pin_sync)
	);

	wire scl_s = pin_sync[3];
	wire sda_s = pin_sync[2];
	wire miso_s = pin_sync[1];
	wire ssn_s = pin_sync[0];
	wire scl_rise = scl_s && !pin_prev_ff[3];
	wire scl_fall = !scl_s && pin_prev_ff[3];
	wire sda_rise = sda_s && !pin_prev_ff[2];
	wire sda_fall = !sda_s && pin_prev_ff[2];

	// ****************************************
	// Register decode
	// ****************************************
	wire wr_spi_control = sfr_wr_in && hit(sfr_addr_in, `SSP_ADDR_SPI_CONTROL);
	wire wr_spi_data = sfr_wr_in && hit(sfr_addr_in, `SSP_ADDR_SPI_DATA);
	wire rd_spi_data = sfr_rd_in && hit(sfr_addr_in, `SSP_ADDR_SPI_DATA);
	wire wr_i2c_control = sfr_wr_in && hit(sfr_addr_in, `SSP_ADDR_I2C_CONTROL);
	wire wr_i2cadr = sfr_wr_in && hit(sfr_addr_in, `SSP_ADDR_I2C_ADDRESS);
	wire wr_i2c_data = sfr_wr_in && hit(sfr_addr_in, `SSP_ADDR_I2C_DATA);
	wire acc_i2c_data = (sfr_wr_in || sfr_rd_in)
		&& hit(sfr_addr_in, `SSP_ADDR_I2C_DATA);

	wire spi_en = spi_ctl_ff[`SSP_SPI_EN_BIT];
	wire master = spi_ctl_ff[`SSP_SPI_MASTER_BIT];
	wire cpol = spi_ctl_ff[`SSP_SPI_CPOL_BIT];
	wire cpha = spi_ctl_ff[`SSP_SPI_CPHA_BIT];
	wire [1:0] spr = spi_ctl_ff[1:0];
	wire i2c_sw_master = i2c_ctl_ff[`SSP_I2C_ROLE_BIT];
	wire sw_master_data_out = i2c_ctl_ff[`SSP_I2C_MDO_BIT];
	wire sw_master_data_drive = i2c_ctl_ff[`SSP_I2C_MDE_BIT];
	wire sw_master_clock_out = i2c_ctl_ff[`SSP_I2C_MCO_BIT];

	// ****************************************
	// SPI engine
	// ****************************************
	logic spi_active_ff;
	logic spi_pend_ff;
	logic [7:0] spi_sh_ff;
	logic spi_out_ff;
	logic [4:0] spi_cnt_ff;
	logic [7:0] spi_div_ff;
	logic sclk_ff;
	logic buf_in_ready;
	logic [7:0] buf_out_data;

	wire slave_sel = spi_en && !master && !ssn_s;
	wire m_tick = spi_active_ff && (spi_div_ff == half_cycles(spr) - 8'h01);
	wire s_lead = cpol ? scl_fall : scl_rise;
	wire spi_edge = master ? m_tick : (slave_sel && (scl_rise || scl_fall));
	wire spi_lead = master ? (sclk_ff == cpol) : s_lead;
	wire spi_sample = spi_edge && (spi_lead ^ cpha);
	wire spi_shift = spi_edge && !(spi_lead ^ cpha);
	wire spi_din = master ? miso_s : sda_s;
	wire spi_done = spi_edge && (spi_cnt_ff == `SSP_SPI_LAST_EDGE);
	wire spi_busy = spi_active_ff || spi_pend_ff || (spi_cnt_ff != 5'h00);
	wire spi_start = spi_pend_ff && !spi_active_ff && buf_in_ready;
	wire [7:0] spi_rx_byte = spi_sample ? {spi_sh_ff[6:0], spi_din}
		: spi_sh_ff;

	// Holding a master start while full keeps unread bytes from being lost
	ssp_buf2 #(.WIDTH(8)) u_rxbuf (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.in_valid_in(spi_done),
		.in_data_in(spi_rx_byte),
		.in_ready_out(buf_in_ready),
		.out_valid_out(),
		.out_ready_in(rd_spi_data),
		.out_data_out(buf_out_data)
	);

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spi_active_ff <= 1'b0;
			spi_pend_ff <= 1'b0;
			spi_cnt_ff <= 5'h00;
			spi_div_ff <= 8'h00;
			sclk_ff <= 1'b0;
		end else begin
			spi_pend_ff <= spi_start ? 1'b0
				: (spi_pend_ff || (wr_spi_data && !spi_busy && master));
			spi_active_ff <= spi_start || (spi_active_ff && !spi_done);
			spi_div_ff <= (!spi_active_ff || m_tick) ? 8'h00
				: spi_div_ff + 8'h01;
			sclk_ff <= !spi_active_ff ? cpol : (sclk_ff ^ m_tick);
			if (!spi_en || (!master && ssn_s) || spi_done) begin
				spi_cnt_ff <= 5'h00;
			end else if (spi_edge) begin
				spi_cnt_ff <= spi_cnt_ff + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spi_sh_ff <= 8'h00;
			spi_out_ff <= 1'b0;
		end else begin
			if (wr_spi_data && !spi_busy) begin
				spi_sh_ff <= sfr_wdata_in;
			end else if (spi_sample) begin
				spi_sh_ff <= spi_rx_byte;
			end
			// Master puts bit 7 out while pending, before any edge
			if (spi_shift || spi_pend_ff || !spi_busy) begin
				spi_out_ff <= spi_sh_ff[7];
			end
		end
	end

	// ****************************************
	// I2C slave engine
	// ****************************************
	ssp_i2c_e i2c_st_ff;
	ssp_i2c_e nxt_i2c_st;
	logic [7:0] i2c_sh_ff;
	logic [7:0] nxt_i2c_sh;
	logic [3:0] i2c_bit_ff;
	logic [3:0] nxt_i2c_bit;
	logic i2c_low_ff;
	logic nxt_i2c_low;
	logic i2c_tx_ff;
	logic nxt_i2c_tx;
	logic byte_evt;
	logic store_rx;

	wire i2c_run = !spi_en && !i2c_sw_master
		&& !i2c_ctl_ff[`SSP_I2C_SRST_BIT];
	wire i2c_start = scl_s && sda_fall;
	wire i2c_stop = scl_s && sda_rise;

	always_comb begin
		nxt_i2c_st = i2c_st_ff;
		nxt_i2c_sh = i2c_sh_ff;
		nxt_i2c_bit = i2c_bit_ff;
		nxt_i2c_low = i2c_low_ff;
		nxt_i2c_tx = i2c_tx_ff;
		byte_evt = 1'b0;
		store_rx = 1'b0;
		if (!i2c_run) begin
			nxt_i2c_st = SSP_I2C_IDLE;
			nxt_i2c_low = 1'b0;
			nxt_i2c_bit = 4'h0;
		end else if (i2c_start) begin
			nxt_i2c_st = SSP_I2C_ADDR;
			nxt_i2c_bit = 4'h0;
			nxt_i2c_low = 1'b0;
		end else if (i2c_stop) begin
			nxt_i2c_st = SSP_I2C_IDLE;
			nxt_i2c_low = 1'b0;
		end else begin
			unique case (i2c_st_ff)
				SSP_I2C_IDLE: begin
				end
				SSP_I2C_ADDR, SSP_I2C_RX: begin
					if (scl_rise) begin
						nxt_i2c_sh = {i2c_sh_ff[6:0], sda_s};
						nxt_i2c_bit = i2c_bit_ff + 4'h1;
					end else if (scl_fall && i2c_bit_ff == 4'h8) begin
						if (i2c_st_ff == SSP_I2C_RX) begin
							nxt_i2c_low = 1'b1;
							nxt_i2c_st = SSP_I2C_RACK;
							store_rx = 1'b1;
							byte_evt = 1'b1;
						end else if (i2c_sh_ff[7:1] == i2c_adr_ff[6:0]) begin
							nxt_i2c_low = 1'b1;
							nxt_i2c_st = SSP_I2C_AACK;
							nxt_i2c_tx = i2c_sh_ff[0];
						end else begin
							nxt_i2c_st = SSP_I2C_IDLE;
						end
					end
				end
				SSP_I2C_AACK, SSP_I2C_RACK: begin
					if (scl_fall) begin
						nxt_i2c_bit = 4'h0;
						if (i2c_tx_ff) begin
							nxt_i2c_st = SSP_I2C_TX;
							nxt_i2c_sh = i2c_dat_ff;
							nxt_i2c_low = !i2c_dat_ff[7];
						end else begin
							nxt_i2c_st = SSP_I2C_RX;
							nxt_i2c_low = 1'b0;
						end
					end
				end
				SSP_I2C_TX: begin
					if (scl_fall && i2c_bit_ff == 4'h7) begin
						nxt_i2c_low = 1'b0;
						nxt_i2c_st = SSP_I2C_TACK;
						byte_evt = 1'b1;
					end else if (scl_fall) begin
						nxt_i2c_bit = i2c_bit_ff + 4'h1;
						nxt_i2c_low = !i2c_sh_ff[6];
						nxt_i2c_sh = {i2c_sh_ff[6:0], 1'b0};
					end
				end
				SSP_I2C_TACK: begin
					// A missing acknowledge ends the read
					if (scl_rise && sda_s) begin
						nxt_i2c_st = SSP_I2C_IDLE;
					end else if (scl_fall) begin
						nxt_i2c_st = SSP_I2C_AACK;
					end
				end
				default: begin
					nxt_i2c_st = SSP_I2C_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			i2c_st_ff <= SSP_I2C_IDLE;
			i2c_sh_ff <= 8'h00;
			i2c_bit_ff <= 4'h0;
			i2c_low_ff <= 1'b0;
			i2c_tx_ff <= 1'b0;
			pin_prev_ff <= 4'hF;
		end else begin
			i2c_st_ff <= nxt_i2c_st;
			i2c_sh_ff <= nxt_i2c_sh;
			i2c_bit_ff <= nxt_i2c_bit;
			i2c_low_ff <= nxt_i2c_low;
			i2c_tx_ff <= nxt_i2c_tx;
			pin_prev_ff <= pin_sync;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	wire [7:0] nxt_spi_ctl = {
		spi_done || (wr_spi_control ? sfr_wdata_in[7]
			: (spi_ctl_ff[7] && !rd_spi_data)),
		(wr_spi_data && spi_busy)
			|| (wr_spi_control ? sfr_wdata_in[6] : spi_ctl_ff[6]),
		wr_spi_control ? sfr_wdata_in[5:0] : spi_ctl_ff[5:0]};
	wire mdi_latch = spi_en || !i2c_sw_master || sw_master_data_drive || !scl_rise;
	wire [7:0] nxt_i2c_ctl = {
		wr_i2c_control ? sfr_wdata_in[7:5] : i2c_ctl_ff[7:5],
		mdi_latch ? i2c_ctl_ff[4] : sda_s,
		wr_i2c_control ? sfr_wdata_in[3:2] : i2c_ctl_ff[3:2],
		i2c_tx_ff,
		byte_evt || (i2c_ctl_ff[0] && !acc_i2c_data)};
	wire [7:0] spi_ctl_view = {spi_ctl_ff[7:1],
		(spi_en && !master) ? ssn_s : spi_ctl_ff[0]};
	wire [7:0] rd_mux =
		hit(sfr_addr_in, `SSP_ADDR_SPI_CONTROL) ? spi_ctl_view
		: hit(sfr_addr_in, `SSP_ADDR_SPI_DATA) ? buf_out_data
		: hit(sfr_addr_in, `SSP_ADDR_I2C_CONTROL) ? i2c_ctl_ff
		: hit(sfr_addr_in, `SSP_ADDR_I2C_ADDRESS) ? i2c_adr_ff
		: hit(sfr_addr_in, `SSP_ADDR_I2C_DATA) ? i2c_dat_ff : 8'h00;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spi_ctl_ff <= `SSP_RST_SPI_CONTROL;
			i2c_ctl_ff <= `SSP_RST_I2C_CONTROL;
			i2c_adr_ff <= `SSP_RST_I2C_ADDRESS;
			i2c_dat_ff <= `SSP_RST_I2C_DATA;
			sfr_rdata_out <= 8'h00;
		end else begin
			spi_ctl_ff <= nxt_spi_ctl;
			i2c_ctl_ff <= nxt_i2c_ctl;
			i2c_adr_ff <= wr_i2cadr ? sfr_wdata_in : i2c_adr_ff;
			i2c_dat_ff <= store_rx ? i2c_sh_ff
				: (wr_i2c_data ? sfr_wdata_in : i2c_dat_ff);
			sfr_rdata_out <= sfr_rd_in ? rd_mux : sfr_rdata_out;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	// I2C pins are open drain: a one releases the line to its pull-up
	wire ssp_pin_s nxt_sclk_drv = spi_en
		? (master ? {sclk_ff, 1'b1} : {1'b0, 1'b0})
		: (i2c_sw_master ? {1'b0, !sw_master_clock_out} : {1'b0, 1'b0});
	wire ssp_pin_s nxt_serial_data_pin_drv = spi_en
		? (master ? {spi_out_ff, 1'b1} : {1'b0, 1'b0})
		: (i2c_sw_master ? {1'b0, sw_master_data_drive && !sw_master_data_out}
			: {1'b0, i2c_low_ff});
	wire ssp_pin_s nxt_miso_drv = (spi_en && !master)
		? {spi_out_ff, slave_sel} : {1'b0, 1'b0};

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			serial_clock_pin_drv_out <= '{1'b0, 1'b0};
			serial_data_pin_drv_out <= '{1'b0, 1'b0};
			miso_pin_drv_out <= '{1'b0, 1'b0};
		end else begin
			serial_clock_pin_drv_out <= nxt_sclk_drv;
			serial_data_pin_drv_out <= nxt_serial_data_pin_drv;
			miso_pin_drv_out <= nxt_miso_drv;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_done_flag;
		@(posedge mclk_in) disable iff (!resetn_in)
		spi_done |=> spi_ctl_ff[`SSP_SPI_DONE_BIT];
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("done flag not set after transfer");

	property p_write_collision_flag;
		@(posedge mclk_in) disable iff (!resetn_in)
		(wr_spi_data && spi_busy) |=> spi_ctl_ff[`SSP_SPI_WRITE_COLLISION_FLAG_BIT]
			&& (spi_sh_ff == $past(spi_rx_byte));
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag)
		else $error("collision not flagged");

	property p_miso_dir;
		@(posedge mclk_in) disable iff (!resetn_in)
		(spi_en && master) |-> ##2 !miso_pin_drv_out.oe || !$past(master);
	endproperty
	a_miso_dir: assert property (p_miso_dir)
		else $error("miso driven in master mode");

	property p_mosi_dir;
		@(posedge mclk_in) disable iff (!resetn_in)
		$past(spi_en) && $past(master) |-> serial_data_pin_drv_out.oe
			&& serial_clock_pin_drv_out.oe;
	endproperty
	a_mosi_dir: assert property (p_mosi_dir)
		else $error("master not driving mosi or clock");

	property p_sclk_slave;
		@(posedge mclk_in) disable iff (!resetn_in)
		$past(spi_en) && !$past(master) |-> !serial_clock_pin_drv_out.oe;
	endproperty
	a_sclk_slave: assert property (p_sclk_slave)
		else $error("clock driven in slave mode");

	property p_idle_level;
		@(posedge mclk_in) disable iff (!resetn_in)
		!spi_active_ff ##1 !spi_active_ff |-> sclk_ff == $past(cpol);
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("serial clock not at idle level");

	property p_i2c_flag;
		@(posedge mclk_in) disable iff (!resetn_in)
		byte_evt |=> i2c_ctl_ff[`SSP_I2C_FLAG_BIT] ##1
			(i2c_ctl_ff[`SSP_I2C_FLAG_BIT] || $past(acc_i2c_data));
	endproperty
	a_i2c_flag: assert property (p_i2c_flag)
		else $error("byte flag lost");

	property p_i2c_reset;
		@(posedge mclk_in) disable iff (!resetn_in)
		!i2c_run |=> i2c_st_ff == SSP_I2C_IDLE && !i2c_low_ff;
	endproperty
	a_i2c_reset: assert property (p_i2c_reset)
		else $error("I2C slave not held idle");
endmodule // ssp_top

// ===== verification/ssp_spi_peer.sv
// Purpose: SPI slave peer on the serial pins
// Assumes: mode bits set like the device's
// Notes: a released output shows the inverse of its last bit
`timescale 1ns/1ps
module ssp_spi_peer (
	input wire logic sclk_in,
	input wire logic mosi_in,
	input wire logic ss_n_in,
	input wire logic cpol_in,
	input wire logic cpha_in,
	input wire logic [7:0] tx_in,
	output logic [7:0] rx_out,
	output logic miso_out
);
	logic [7:0] sh;
	logic q = 1'b0;
	// Floating line must not look like held data
	assign miso_out = ss_n_in ? ~q : q;
	// Phase 0 needs bit 7 out before the first edge
	always @(negedge ss_n_in) begin
		sh = tx_in;
		if (!cpha_in) begin
			q = sh[7];
			sh = sh << 1;
		end
	end
	// Sample on one edge, launch on the other
	always @(sclk_in) begin
		if (ss_n_in === 1'b0) begin
			if ((sclk_in !== cpol_in) ^ cpha_in)
				rx_out = {rx_out[6:0], mosi_in};
			else begin
				q = sh[7];
				sh = sh << 1;
			end
		end
	end
endmodule // ssp_spi_peer

// ===== verification/ssp_top_tb_top.sv
// Purpose: self-checking bench of the shared serial port
// Assumes: registers on the strobe port, peer on SPI pins
// Notes: open-drain lines resolve to a pull-up level
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_top_tb_top;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] dtx;
		logic [7:0] ptx;
	} ssp_row_s;
	ssp_row_s rows [4] = '{'{8'h33, 8'hA5, 8'h5A}, '{8'h36, 8'h3C, 8'hC3},
		'{8'h3B, 8'h81, 8'h7E}, '{8'h3E, 8'h5E, 8'hE1}};
	logic [7:0] ra [5] = '{8'hF8, 8'hE8, 8'h9B, 8'h9A, 8'h10};
	logic [7:0] rv [5] = '{8'h04, 8'h00, 8'h55, 8'h00, 8'h00};
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, d, m, peer_rx;
	logic ack;
	logic [7:0] ptx = 8'h00;
	logic tb_sclk = 1'b0;
	logic tb_sda = 1'b1;
	logic ss_n = 1'b1;
	logic pcpol = 1'b0;
	logic pcpha = 1'b0;
	logic peer_miso;
	ssp_pkg::ssp_pin_s sclk_drv, sda_drv, miso_drv;
	int n_errors = 0;
	int comparisons = 0;
	wire sclk_w = sclk_drv.oe ? sclk_drv.out : tb_sclk;
	wire sda_w = sda_drv.oe ? sda_drv.out : tb_sda;
	wire miso_w = miso_drv.oe ? miso_drv.out : peer_miso;

	always #2.5 mclk_in = ~mclk_in;

	ssp_top #(.HALF_BASE(1)) u_ssp_top (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
		.serial_clock_pin_in(sclk_w), .serial_clock_pin_drv_out(sclk_drv),
		.serial_data_pin_in(sda_w), .serial_data_pin_drv_out(sda_drv),
		.miso_pin_in(miso_w), .miso_pin_drv_out(miso_drv),
		.slave_select_n_in(ss_n));
	ssp_spi_peer u_ssp_spi_peer (.sclk_in(sclk_w), .mosi_in(sda_w),
		.ss_n_in(ss_n), .cpol_in(pcpol), .cpha_in(pcpha), .tx_in(ptx),
		.rx_out(peer_rx), .miso_out(peer_miso));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Bounded poll; a read of the data would clear the flag
	task automatic wait_done;
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 300 && v[7] !== 1'b1; i++)
			rd_reg(8'hF8, v);
		check({7'h0, v[7]}, 8'h01);
	endtask
	// Bench as I2C master; data changes while the clock is low, except at start and stop
	task automatic bus_start;
		@(posedge mclk_in);
		tb_sda <= 1'b0;
		repeat (6) @(posedge mclk_in);
		tb_sclk <= 1'b0;
	endtask
	task automatic bus_stop;
		repeat (6) @(posedge mclk_in);
		tb_sda <= 1'b0;
		repeat (6) @(posedge mclk_in);
		tb_sclk <= 1'b1;
		repeat (6) @(posedge mclk_in);
		tb_sda <= 1'b1;
		repeat (6) @(posedge mclk_in);
	endtask
	// Eight data clocks, then a ninth with the line released
	task automatic i2c_byte(input logic [7:0] b, output logic a);
		for (int i = 8; i >= 0; i--) begin
			repeat (6) @(posedge mclk_in);
			tb_sda <= 1'({b, 1'b1} >> i);
			repeat (6) @(posedge mclk_in);
			tb_sclk <= 1'b1;
			repeat (6) @(posedge mclk_in);
			a = !sda_w;
			repeat (6) @(posedge mclk_in);
			tb_sclk <= 1'b0;
		end
	endtask
	task automatic test_done;
		$display("TB: errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge mclk_in);
		n_errors++;
		test_done();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (8) @(posedge mclk_in);
		resetn_in <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr_reg(8'hF8, rows[k].ctrl);
			pcpol <= rows[k].ctrl[3];
			pcpha <= rows[k].ctrl[2];
			ptx <= rows[k].ptx;
			repeat (4) @(posedge mclk_in);
			ss_n <= 1'b0;
			wr_reg(`SSP_ADDR_SPI_DATA, rows[k].dtx);
			wait_done();
			check({7'h0, sclk_w}, {7'h0, rows[k].ctrl[3]});
			check(peer_rx, rows[k].dtx);
			rd_reg(`SSP_ADDR_SPI_DATA, d);
			check(d, rows[k].ptx);
			rd_reg(8'hF8, d);
			check({7'h0, d[7]}, 8'h00);
			ss_n <= 1'b1;
			$display("TB: master row %0d done", k);
		end
		// Second write mid-transfer is dropped
		repeat (4) @(posedge mclk_in);
		ss_n <= 1'b0;
		wr_reg(`SSP_ADDR_SPI_DATA, 8'h99);
		wr_reg(`SSP_ADDR_SPI_DATA, 8'h66);
		rd_reg(8'hF8, d);
		check({7'h0, d[6]}, 8'h01);
		wait_done();
		check(peer_rx, 8'h99);
		rd_reg(`SSP_ADDR_SPI_DATA, d);
		check(d, 8'hE1);
		wr_reg(8'hF8, 8'h3E);
		rd_reg(8'hF8, d);
		check(d, 8'h3E);
		ss_n <= 1'b1;
		$display("TB: collision done");
		// Slave, phase 1, bench as master at 125 ns
		wr_reg(8'hF8, 8'h24);
		wr_reg(`SSP_ADDR_SPI_DATA, 8'hC6);
		rd_reg(8'hF8, d);
		check({7'h0, d[0]}, 8'h01);
		check({6'h0, miso_drv.oe, sclk_drv.oe}, 8'h00);
		ss_n <= 1'b0;
		repeat (4) @(posedge mclk_in);
		rd_reg(8'hF8, d);
		check({7'h0, d[0]}, 8'h00);
		m = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			@(posedge mclk_in);
			tb_sclk <= 1'b1;
			tb_sda <= 1'(8'h3A >> i);
			repeat (12) @(posedge mclk_in);
			tb_sclk <= 1'b0;
			m = {m[6:0], miso_w};
			repeat (12) @(posedge mclk_in);
		end
		check({6'h0, miso_drv.oe, sda_drv.oe}, 8'h02);
		ss_n <= 1'b1;
		wait_done();
		check(m, 8'hC6);
		rd_reg(`SSP_ADDR_SPI_DATA, d);
		check(d, 8'h3A);
		check({7'h0, miso_drv.oe}, 8'h00);
		$display("TB: slave done");
		// Software-driven I2C master on shared pins
		tb_sclk <= 1'b1;
		tb_sda <= 1'b1;
		wr_reg(8'hF8, 8'h04);
		wr_reg(8'hE8, 8'hE8);
		repeat (3) @(posedge mclk_in);
		check({6'h0, sclk_w, sda_w}, 8'h03);
		wr_reg(8'hE8, 8'h48);
		repeat (3) @(posedge mclk_in);
		check({6'h0, sclk_w, sda_w}, 8'h00);
		wr_reg(8'hE8, 8'h08);
		tb_sda <= 1'b0;
		wr_reg(8'hE8, 8'h28);
		repeat (4) @(posedge mclk_in);
		rd_reg(8'hE8, d);
		check({7'h0, d[4]}, 8'h00);
		check({7'h0, sda_drv.oe}, 8'h00);
		tb_sda <= 1'b1;
		wr_reg(8'hE8, 8'h08);
		wr_reg(8'hE8, 8'h28);
		repeat (4) @(posedge mclk_in);
		rd_reg(8'hE8, d);
		check(d, 8'h38);
		$display("TB: i2c master done");
		// Reset in mid-run, then defaults and access kinds
		@(posedge mclk_in);
		resetn_in <= 1'b0;
		repeat (8) @(posedge mclk_in);
		check({5'h0, sclk_drv.oe, sda_drv.oe, miso_drv.oe}, 8'h00);
		resetn_in <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			rd_reg(ra[k], d);
			check(d, rv[k]);
		end
		wr_reg(8'h9B, 8'hAA);
		wr_reg(8'h10, 8'hFF);
		rd_reg(8'h9B, d);
		check(d, 8'hAA);
		rd_reg(8'h10, d);
		check(d, 8'h00);
		$display("TB: reset done");
		// Hardware I2C slave at address 2A, bench as master
		bus_start();
		i2c_byte(8'h56, ack);
		check({7'h0, ack}, 8'h00);
		bus_stop();
		bus_start();
		i2c_byte(8'h54, ack);
		check({7'h0, ack}, 8'h01);
		i2c_byte(8'hC3, ack);
		check({7'h0, ack}, 8'h01);
		bus_stop();
		rd_reg(8'hE8, d);
		check(d, 8'h01);
		rd_reg(8'h9A, d);
		check(d, 8'hC3);
		rd_reg(8'hE8, d);
		check(d, 8'h00);
		bus_start();
		i2c_byte(8'h55, ack);
		check({7'h0, ack}, 8'h01);
		rd_reg(8'hE8, d);
		check(d, 8'h02);
		bus_stop();
		wr_reg(8'hE8, 8'h04);
		bus_start();
		i2c_byte(8'h54, ack);
		check({7'h0, ack}, 8'h00);
		bus_stop();
		$display("TB: i2c slave done");
		test_done();
	end
endmodule // ssp_top_tb_top
